/* bench/pmce_engine_monitor.sv */
// port checker for the checksum engine
`timescale 1ns/10ps
module pmce_engine_monitor
  import pmce_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // memory
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic prev_rd;
  logic acc;
  assign acc = psel && penable && pready && pwrite && !mem_rd && !prev_rd;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_rd <= 1'b0;
    else prev_rd <= mem_rd;
  end
  blk_start_a:
    assert property (acc && paddr == 12'h000 |=> mem_rd &&
      mem_addr == {$past(pwdata[7:0]), 8'h00}) else $error("block start");
  full_start_a:
    assert property (acc && paddr == 12'h004 |=> mem_rd &&
      mem_addr == 16'h0000) else $error("full start");
  read_pulse_a:
    assert property (mem_rd |=> !mem_rd) else $error("read pulse");
  addr_step_a:
    assert property (mem_rd ##2 mem_rd |->
      mem_addr == $past(mem_addr, 2) + 16'h0001) else $error("addr step");
  addr_range_a:
    assert property (mem_rd |-> mem_addr <= PMCE_MEM_LAST)
      else $error("addr range");
  apb_wait_a: assert property (psel && !penable |=> pready)
    else $error("apb wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready pulse");
  unmapped_a: assert property (psel && penable && pready &&
    paddr > 12'h010 |-> pslverr) else $error("unmapped");
  cover property (acc && paddr == 12'h000);
  cover property (acc && paddr == 12'h004);
  cover property (pready && pslverr);
endmodule

/* bench/pmce_mem_model.sv */
// program memory model, one cycle registered read
`timescale 1ns/10ps
module pmce_mem_model (
  // clock
  input wire logic pclk,
  // read port
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata
);
  initial mem_rdata = 8'h00;
  // valid one cycle after strobe, toggles otherwise
  always @(posedge pclk)
    if (mem_rd) mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A;
    else mem_rdata <= ~mem_rdata;
endmodule

/* bench/program_memory_crc_engine_test.sv */
// self-checking bench for the checksum engine
`timescale 1ns/10ps
module program_memory_crc_engine_test;
  import pmce_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_rd;
  logic mem_read_lock, mem_write_lock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] last_e;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  pmce_engine u_pmce_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_read_lock(mem_read_lock), .mem_write_lock(mem_write_lock));
  pmce_mem_model u_pmce_mem_model (.pclk(pclk), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] crc(input logic f, input logic [15:0] s);
    logic [31:0] c;
    logic [15:0] a;
    logic fb;
    c = 32'h00000000;
    for (int i = 0; i < (f ? 8192 : 256); i++) begin
      a = s + 16'(i);
      a[7:0] = a[7:0] ^ a[15:8] ^ 8'h5A;
      for (int k = 7; k >= 0; k--) begin
        fb = (f ? c[31] : c[15]) ^ a[k];
        c = (c << 1) ^ (fb ? (f ? 32'h04C11DB7 : 32'h00001021) : 32'h0);
        if (!f) c[31:16] = 16'h0000;
      end
    end
    return c;
  endfunction
  task automatic run(input logic f, input logic [7:0] hi);
    logic [31:0] e;
    e = crc(f, f ? 16'h0000 : {hi, 8'h00});
    apb(1'b1, f ? 12'h004 : 12'h000, hi);
    apb(1'b0, 12'h010, 8'h00);
    chk(rd, {28'h0, mem_write_lock, mem_read_lock, f, 1'b1});
    apb(1'b1, 12'h000, 8'h11);
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, {24'h0, last_e[7:0]});
    do apb(1'b0, 12'h010, 8'h00); while (rd[0] === 1'b1);
    chk(rd, {28'h0, mem_write_lock, mem_read_lock, f, 1'b0});
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 8'h00);
      chk(rd, {24'h0, e[i*8 +: 8]});
    end
    last_e = e;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    last_e = 32'h0;
    mem_read_lock = 1'b1;
    mem_write_lock = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 8'h00);
      chk(rd, {28'h0, i == 4 ? 4'hC : 4'h0});
    end
    apb(1'b1, 12'h00C, 8'hAA);
    apb(1'b0, 12'h00C, 8'h00);
    chk(rd, 32'h0);
    run(1'b0, 8'h02);
    run(1'b0, 8'h1F);
    presetn <= 1'b0;
    mem_read_lock <= 1'b0;
    last_e = 32'h0;
    @(posedge pclk);
    presetn <= 1'b1;
    run(1'b1, 8'h00);
    report_and_stop();
  end
endmodule
bind pmce_engine pmce_engine_monitor u_pmce_engine_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .mem_rd(mem_rd), .mem_addr(mem_addr));

/* shared/pmce_pkg.sv */
// constants, types and decoding shared by the checksum engine
package pmce_pkg;

  // program memory address space
  localparam int PMCE_AW = 16;
  localparam logic [PMCE_AW-1:0] PMCE_MEM_FIRST = 16'h0000;
  localparam logic [PMCE_AW-1:0] PMCE_MEM_LAST = 16'h1FFF;
  localparam logic [7:0] PMCE_BLK_LO_FIRST = 8'h00;
  localparam logic [7:0] PMCE_BLK_LO_LAST = 8'hFF;

  // generator polynomials and seeds
  localparam int PMCE_W32 = 32;
  localparam int PMCE_W16 = 16;
  localparam logic [31:0] PMCE_POLY32 = 32'h04C11DB7;
  localparam logic [31:0] PMCE_POLY16 = 32'h00001021;
  localparam logic [31:0] PMCE_SEED32 = 32'h00000000;
  localparam logic [15:0] PMCE_SEED16 = 16'h0000;

  // register byte offsets on the apb window
  localparam int PMCE_OFS_W = 12;
  localparam logic [11:0] PMCE_OFS_BYTE0 = 12'h000;
  localparam logic [11:0] PMCE_OFS_BYTE1 = 12'h004;
  localparam logic [11:0] PMCE_OFS_BYTE2 = 12'h008;
  localparam logic [11:0] PMCE_OFS_BYTE3 = 12'h00C;
  localparam logic [11:0] PMCE_OFS_STAT = 12'h010;

  // status register bit positions
  localparam int PMCE_ST_BUSY = 0;
  localparam int PMCE_ST_FULL = 1;
  localparam int PMCE_ST_RLOCK = 2;
  localparam int PMCE_ST_WLOCK = 3;

  typedef enum logic [1:0] {
    PMCE_IDLE,
    PMCE_READ,
    PMCE_DATA
  } pmce_phase_t;

  typedef enum logic [2:0] {
    PMCE_R_BYTE0,
    PMCE_R_BYTE1,
    PMCE_R_BYTE2,
    PMCE_R_BYTE3,
    PMCE_R_STAT,
    PMCE_R_NONE
  } pmce_reg_t;

  // byte offset to register select
  function automatic pmce_reg_t pmce_decode(input logic [11:0] ofs);
    pmce_reg_t r;
    r = PMCE_R_NONE;
    case (ofs)
      PMCE_OFS_BYTE0: r = PMCE_R_BYTE0;
      PMCE_OFS_BYTE1: r = PMCE_R_BYTE1;
      PMCE_OFS_BYTE2: r = PMCE_R_BYTE2;
      PMCE_OFS_BYTE3: r = PMCE_R_BYTE3;
      PMCE_OFS_STAT: r = PMCE_R_STAT;
      default: r = PMCE_R_NONE;
    endcase
    return r;
  endfunction

endpackage

/* verilog/pmce_crc_step.sv */
// one byte step of an msb-first crc, width and polynomial set by parameters
`timescale 1ns/10ps
module pmce_crc_step
  import pmce_pkg::*;
#(
  parameter int W = 16,
  parameter logic [31:0] POLY = 32'h00001021
) (
  // running value in
  input wire logic [W-1:0] crc_in,
  input wire logic [7:0] data,
  // running value out
  output logic [W-1:0] crc_out
);

  logic [W-1:0] chain [0:8];

  assign chain[0] = crc_in;

  ////////////////////////////////////////////////////////////////////////
  // one shift per data bit, msb first
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic fb;
      assign fb = chain[i][W-1] ^ data[7-i];
      assign chain[i+1] = {chain[i][W-2:0], 1'b0} ^
        (fb ? POLY[W-1:0] : '0);
    end
  endgenerate

  assign crc_out = chain[8];

endmodule

/* verilog/pmce_engine.sv */
// program memory checksum engine with apb register access
//
// Functional notes
// - block crc16 and full-memory crc32 supported
// - block covers only aligned 256-byte ranges
// - lock state never blocks a checksum
// - write to byte one starts crc32
// - crc32 runs from address zero to end
// - busy flag set while any checksum runs
// - crc32 result bytes three down to zero
// - crc32 polynomial is 0x04C11DB7
// - write to byte zero starts block crc
// - crc16 result in bytes one and zero
// - crc16 polynomial is 0x1021
`timescale 1ns/10ps
module pmce_engine
  import pmce_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // program memory read port
  output logic mem_rd,
  output logic [PMCE_AW-1:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // memory lock state
  input wire logic mem_read_lock,
  input wire logic mem_write_lock
);

  typedef struct packed {
    pmce_phase_t phase;
    logic full;
    logic busy;
    logic [PMCE_AW-1:0] addr;
    logic [PMCE_AW-1:0] last;
    logic [31:0] crc32;
    logic [15:0] crc16;
    logic [31:0] result;
    logic mem_rd;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pmce_state_t;

  pmce_state_t s;
  pmce_state_t next_s;

  logic [31:0] step32;
  logic [15:0] step16;

  ////////////////////////////////////////////////////////////////////////
  // crc datapaths

  pmce_crc_step #(
    .W(PMCE_W32),
    .POLY(PMCE_POLY32)
  ) u_step32 (
    .crc_in(s.crc32),
    .data(mem_rdata),
    .crc_out(step32)
  );

  pmce_crc_step #(
    .W(PMCE_W16),
    .POLY(PMCE_POLY16)
  ) u_step16 (
    .crc_in(s.crc16),
    .data(mem_rdata),
    .crc_out(step16)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic setup;
    logic access;
    pmce_reg_t rsel;
    logic [31:0] rval;
    setup = 1'b0;
    access = 1'b0;
    rsel = PMCE_R_NONE;
    rval = 32'h00000000;
    next_s = s;

    // apb phases, no wait states, pready set for the first access cycle
    setup = psel && !penable;
    access = psel && penable && s.pready;
    rsel = pmce_decode(paddr);
    next_s.pready = setup && !s.pready;

    // read data captured in the setup cycle
    case (rsel)
      PMCE_R_BYTE0: rval = {24'h000000, s.result[7:0]};
      PMCE_R_BYTE1: rval = {24'h000000, s.result[15:8]};
      PMCE_R_BYTE2: rval = {24'h000000, s.result[23:16]};
      PMCE_R_BYTE3: rval = {24'h000000, s.result[31:24]};
      PMCE_R_STAT: begin
        rval[PMCE_ST_BUSY] = s.busy;
        rval[PMCE_ST_FULL] = s.full;
        rval[PMCE_ST_RLOCK] = mem_read_lock;
        rval[PMCE_ST_WLOCK] = mem_write_lock;
      end
      default: rval = 32'h00000000;
    endcase
    if (setup) begin
      next_s.prdata = pwrite ? 32'h00000000 : rval;
      next_s.pslverr = (rsel == PMCE_R_NONE);
    end

    // start requests, ignored while busy; locks not consulted
    if (access && pwrite && !s.busy) begin
      case (rsel)
        PMCE_R_BYTE1: begin
          next_s.full = 1'b1;
          next_s.busy = 1'b1;
          next_s.addr = PMCE_MEM_FIRST;
          next_s.last = PMCE_MEM_LAST;
          next_s.crc32 = PMCE_SEED32;
          next_s.phase = PMCE_READ;
          next_s.mem_rd = 1'b1;
        end
        PMCE_R_BYTE0: begin
          next_s.full = 1'b0;
          next_s.busy = 1'b1;
          next_s.addr = {pwdata[7:0], PMCE_BLK_LO_FIRST};
          next_s.last = {pwdata[7:0], PMCE_BLK_LO_LAST};
          next_s.crc16 = PMCE_SEED16;
          next_s.phase = PMCE_READ;
          next_s.mem_rd = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // byte walk over the selected range
    case (s.phase)
      PMCE_IDLE: begin
      end
      PMCE_READ: begin
        next_s.mem_rd = 1'b0;
        next_s.phase = PMCE_DATA;
      end
      PMCE_DATA: begin
        if (s.full) begin
          next_s.crc32 = step32;
        end else begin
          next_s.crc16 = step16;
        end
        if (s.addr == s.last) begin
          next_s.phase = PMCE_IDLE;
          next_s.busy = 1'b0;
          if (s.full) begin
            next_s.result = step32;
          end else begin
            next_s.result = {16'h0000, step16};
          end
        end else begin
          next_s.addr = s.addr + 16'h0001;
          next_s.mem_rd = 1'b1;
          next_s.phase = PMCE_READ;
        end
      end
      default: begin
        next_s.phase = PMCE_IDLE;
        next_s.busy = 1'b0;
        next_s.mem_rd = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign mem_rd = s.mem_rd;
  assign mem_addr = s.addr;

endmodule
